// ===== hw/desc_ram.sv
// 512-byte descriptor store, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none

module desc_ram (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // write side
  input  wire logic       we,
  input  wire logic [8:0] waddr,
  input  wire logic [7:0] wdata,
  // read side
  input  wire logic [8:0] raddr,
  output var  logic [7:0] rdata_q
);

  logic [7:0] mem [0:511];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// ===== hw/eeprom_config_image_loader.sv
// loader that reads the configuration image and spreads it over config fields
`timescale 1ns/10ps
`default_nettype none
`include "loader_map.svh"

// Summary of operation
// R1: image counts as programmed only if byte zero holds the marker value
// R2: every offset in the image counts 16-bit words, not bytes
// R3: a zero length marks the item absent; its default is kept
// R4: programmer stores device descriptor length of zero or eighteen only
// R5: programmer stores configuration/interface length of zero or eighteen only
// R6: programmer stores SuperSpeed configuration block length zero or eighteen only
// R7: binary object store length is taken as any value
// R8: programmer zeroes string index fields of absent strings
// R9: no language code is reported when all string lengths are zero
// R10: programmer writes zero into every reserved bit
// R11: byte 07h feeds wake enable bits 7:0, byte 08h low nibble bits 11:8
// R12: byte 0Eh feeds wake polarity bits 7:0, byte 0Fh bits 11:8
// R13: polling intervals full, high and SuperSpeed come from 10h, 11h, 12h
// R14: four flag words built from bytes 13h to 22h, low byte first
// R15: string length/offset pairs from 25h: maker, product, serial, config, interface
// R16: MAC address built from bytes 01h to 06h, low byte first
// R17: language code is byte 23h low, byte 24h high
// R18: after reset the first byte is read; no marker ends the load with defaults
// R19: a programmed image is copied into the 512-byte descriptor store
// R20: PHY stays disconnected until the full load has finished
// R21: a USB bus reset reloads only the MAC address
module eeprom_config_image_loader
  import loader_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // load triggers
  input  wire logic        sys_reload,
  input  wire logic        usb_reset,
  // byte fetch from the serial memory sequencer
  output logic             ee_req,
  output var  logic [8:0]  ee_addr,
  input  wire logic        ee_valid,
  input  wire logic [7:0]  ee_data,
  // descriptor store read port
  input  wire logic [8:0]  desc_addr,
  output logic      [7:0]  desc_data,
  // configuration outputs
  output logic      [47:0] mac_addr,
  output logic      [11:0] gpio_wake_enable_field,
  output logic      [11:0] gpio_wake_polarity_field,
  output var  logic        phy_disconnect,
  output var  logic        load_done,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata
);

  // ==========================================================
  // sequencer
  load_state_t state_q;
  load_mode_t  mode_q;
  logic [8:0]  addr_q;
  logic        take;
  logic        bad_mark;
  logic        last_byte;
  logic        start_full;
  logic        start_mac;
  logic        idle;

  assign idle       = (state_q == ST_IDLE);
  assign take       = (state_q == ST_FETCH) && ee_valid;
  assign start_full = sys_reload ||
                      (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_FULL]);
  assign start_mac  = usb_reset ||
                      (reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_MAC]);
  assign bad_mark   = take && addr_q == `IMG_MARK_ADDR && ee_data != `IMG_MARK; // R1
  assign last_byte  = (mode_q == MODE_MAC) ? (addr_q == `IMG_MAC5) // R21
                                           : (addr_q == `IMG_LAST);
  assign ee_req     = (state_q == ST_FETCH);
  assign ee_addr    = addr_q;

  // the first load starts straight out of reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_FETCH;
      mode_q  <= MODE_FULL;
      addr_q  <= 9'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_full) begin
            state_q <= ST_FETCH;
            mode_q  <= MODE_FULL;
            addr_q  <= 9'h000;
          end else if (start_mac) begin
            state_q <= ST_FETCH;
            mode_q  <= MODE_MAC; // R21
            addr_q  <= 9'h000;
          end
        end
        ST_FETCH: begin
          if (take) begin
            if (bad_mark || last_byte) begin
              state_q <= ST_FINISH; // R18
            end else begin
              addr_q <= addr_q + 9'h001;
            end
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // load status and PHY hold-off
  logic programmed_q;
  logic clr_fields;

  assign clr_fields = idle && start_full;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      programmed_q <= 1'b0;
    end else if (take && addr_q == `IMG_MARK_ADDR) begin
      programmed_q <= (ee_data == `IMG_MARK); // R1
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phy_disconnect <= 1'b1;
    end else if (clr_fields) begin
      phy_disconnect <= 1'b1; // R20
    end else if (state_q == ST_FINISH && mode_q == MODE_FULL) begin
      phy_disconnect <= 1'b0; // R20
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      load_done <= 1'b0;
    end else if (clr_fields) begin
      load_done <= 1'b0;
    end else if (state_q == ST_FINISH && mode_q == MODE_FULL) begin
      load_done <= 1'b1;
    end
  end

  // ==========================================================
  // descriptor store copy
  logic ram_we;

  assign ram_we = take && mode_q == MODE_FULL && !bad_mark; // R19

  desc_ram u_desc_ram (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .we      (ram_we),
    .waddr   (addr_q),
    .wdata   (ee_data),
    .raddr   (desc_addr),
    .rdata_q (desc_data)
  );

  // ==========================================================
  // decoded header bytes, each back to its default on a full load
  logic [7:0] img_q [1:`IMG_TOP];

  for (genvar g = 1; g <= `IMG_TOP; g++) begin : g_img
    localparam logic [7:0] DEF = (g >= `IMG_IV_FS && g <= `IMG_IV_SS) ? `DEF_IV
                                                                        : `DEF_BYTE;
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        img_q[g] <= DEF;
      end else if (clr_fields) begin
        img_q[g] <= DEF; // R3
      end else if (take && addr_q == 9'(g)) begin
        img_q[g] <= ee_data;
      end
    end
  end

  // ==========================================================
  // field assembly
  logic [7:0]  ival_fs;
  logic [7:0]  ival_hs;
  logic [7:0]  ival_ss;
  logic [15:0] lang_id;
  logic [31:0] cfg_flags [0:3];
  logic [7:0]  str_len [0:4];
  logic [8:0]  str_baddr [0:4];
  logic [4:0]  str_present;
  logic        lang_supported;
  logic [7:0]  bos_len;
  logic [8:0]  bos_baddr;
  logic [5:0]  fix_bad;
  logic        len_err;

  assign mac_addr = {img_q[6], img_q[5], img_q[4], img_q[3], img_q[2], img_q[1]}; // R16
  assign gpio_wake_enable_field   = {img_q[8][3:0], img_q[7]}; // R11
  assign gpio_wake_polarity_field = {img_q[15][3:0], img_q[14]}; // R12
  assign ival_fs = img_q[16]; // R13
  assign ival_hs = img_q[17]; // R13
  assign ival_ss = img_q[18]; // R13
  assign lang_id = {img_q[36], img_q[35]}; // R17

  for (genvar w = 0; w < 4; w++) begin : g_flags
    localparam int B = 19 + 4 * w;
    assign cfg_flags[w] = {img_q[B+3], img_q[B+2], img_q[B+1], img_q[B]}; // R14
  end

  for (genvar k = 0; k < 5; k++) begin : g_str
    assign str_len[k]     = img_q[37 + 2 * k]; // R15
    assign str_baddr[k]   = {img_q[38 + 2 * k], 1'b0}; // R2
    assign str_present[k] = (str_len[k] != 8'h00); // R3
  end

  assign lang_supported = |str_present; // R9
  assign bos_len        = img_q[47]; // R7
  assign bos_baddr      = {img_q[48], 1'b0}; // R2

  // fixed-size blocks must read zero or eighteen; anything else is flagged
  for (genvar j = 0; j < 6; j++) begin : g_fix
    localparam int F = 49 + 2 * j;
    assign fix_bad[j] = img_q[F] != 8'h00 && img_q[F] != `IMG_FIX_LEN;
  end

  assign len_err = |fix_bad;

  // ==========================================================
  // register read port
  logic [31:0] rd_d;
  logic [31:0] str_word [0:4];

  for (genvar s = 0; s < 5; s++) begin : g_strw
    assign str_word[s] = {str_present[s], 6'h00, str_baddr[s], 8'h00, str_len[s]};
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
      `REG_STATUS: begin
        rd_d = {27'h0, len_err, lang_supported, !idle, programmed_q, load_done};
      end
      `REG_MAC_LO: begin
        rd_d = mac_addr[31:0];
      end
      `REG_MAC_HI: begin
        rd_d = {16'h0000, mac_addr[47:32]};
      end
      `REG_WAKE: begin
        rd_d = {4'h0, gpio_wake_polarity_field, 4'h0, gpio_wake_enable_field};
      end
      `REG_IVAL: begin
        rd_d = {8'h00, ival_ss, ival_hs, ival_fs};
      end
      `REG_LANG: begin
        rd_d = {16'h0000, lang_supported ? lang_id : 16'h0000}; // R9
      end
      `REG_BOS: begin
        rd_d = {7'h00, bos_baddr, 8'h00, bos_len};
      end
      default: begin
        for (int f = 0; f < 4; f++) begin
          if (reg_addr == `REG_FLAGS0 + 8'(4 * f)) begin
            rd_d = cfg_flags[f];
          end
        end
        for (int t = 0; t < 5; t++) begin
          if (reg_addr == `REG_STR0 + 8'(4 * t)) begin
            rd_d = str_word[t];
          end
        end
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_reject;
    state_q == ST_FINISH ##1 state_q == ST_IDLE && !programmed_q;
  endsequence
  sequence s_full_end;
    state_q == ST_FINISH && mode_q == MODE_FULL;
  endsequence

  mark_reject_a: // R18
    assert property (bad_mark |=> s_reject)
    else $error("missing marker did not end the load");

  phy_hold_a: // R20
    assert property (mode_q == MODE_FULL && !idle |-> phy_disconnect)
    else $error("phy released before full load ended");

  phy_release_a: // R20
    assert property (s_full_end |=> !phy_disconnect && load_done)
    else $error("phy not released after full load");

  ram_copy_a: // R19
    assert property (take && mode_q == MODE_FULL && |addr_q
                     |=> u_desc_ram.mem[$past(addr_q)] == $past(ee_data))
    else $error("image byte not copied to descriptor store");

  mac_only_a: // R21
    assert property (mode_q == MODE_MAC && take |-> addr_q <= `IMG_MAC5)
    else $error("bus reset reload went past the MAC bytes");

  mac_load_a: // R16
    assert property (take && addr_q == `IMG_MAC5 |=> mac_addr[47:40] == $past(ee_data))
    else $error("MAC high byte not loaded");

  wake_load_a: // R11
    assert property (take && addr_q == `IMG_WK_HI
                     |=> gpio_wake_enable_field[11:8] == $past(ee_data[3:0]))
    else $error("wake enable high bits wrong");

  pol_load_a: // R12
    assert property (take && addr_q == `IMG_POL_LO
                     |=> gpio_wake_polarity_field[7:0] == $past(ee_data))
    else $error("wake polarity low bits wrong");

  ival_load_a: // R13
    assert property (take && addr_q == `IMG_IV_SS |=> ival_ss == $past(ee_data))
    else $error("SuperSpeed interval not loaded");

  flags_load_a: // R14
    assert property (take && addr_q == `IMG_FLAGS0 + 9'h003
                     |=> cfg_flags[0][31:24] == $past(ee_data))
    else $error("flag word 0 top byte wrong");

  lang_load_a: // R17
    assert property (take && addr_q == `IMG_LANG_HI |=> lang_id[15:8] == $past(ee_data))
    else $error("language code high byte wrong");

  str_offset_a: // R2
    assert property (take && addr_q == `IMG_STR0 + 9'h001
                     |=> str_baddr[0] == {$past(ee_data), 1'b0})
    else $error("string word offset not doubled");

  str_absent_a: // R3
    assert property (take && addr_q == `IMG_STR0 && ee_data == 8'h00 |=> !str_present[0])
    else $error("zero length string counted present");

  lang_gate_a: // R9
    assert property (!lang_supported && reg_rd && reg_addr == `REG_LANG
                     |=> reg_rdata == 32'h0000_0000)
    else $error("language code shown without strings");

  bos_len_a: // R7
    assert property (take && addr_q == `IMG_BOS_LEN |=> bos_len == $past(ee_data))
    else $error("object store length not taken as stored");

endmodule

`default_nettype wire

// ===== hw/loader_map.svh
// offsets, field positions, reset values and register map of the image loader
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH

// ==========================================================
// image layout (byte addresses in the serial memory)
`define IMG_MARK_ADDR  9'h000
`define IMG_MARK       8'ha5
`define IMG_LAST       9'h1ff
`define IMG_MAC0       9'h001
`define IMG_MAC5       9'h006
`define IMG_WK_LO      9'h007
`define IMG_WK_HI      9'h008
`define IMG_POL_LO     9'h00e
`define IMG_POL_HI     9'h00f
`define IMG_IV_FS      9'h010
`define IMG_IV_HS      9'h011
`define IMG_IV_SS      9'h012
`define IMG_FLAGS0     9'h013
`define IMG_LANG_LO    9'h023
`define IMG_LANG_HI    9'h024
`define IMG_STR0       9'h025
`define IMG_BOS_LEN    9'h02f
`define IMG_BOS_OFS    9'h030
`define IMG_FIX0       9'h031
`define IMG_TOP        60
`define IMG_FIX_LEN    8'h12

// ==========================================================
// hardware defaults kept when the image is absent
`define DEF_BYTE       8'h00
`define DEF_IV         8'h01

// ==========================================================
// register map (byte addresses, 32-bit words)
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_MAC_LO     8'h08
`define REG_MAC_HI     8'h0c
`define REG_WAKE       8'h10
`define REG_IVAL       8'h14
`define REG_LANG       8'h18
`define REG_FLAGS0     8'h1c
`define REG_STR0       8'h2c
`define REG_BOS        8'h40
`define CTRL_FULL      0
`define CTRL_MAC       1

`endif

// ===== hw/loader_pkg.sv
// types shared by the image loader
package loader_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FETCH  = 3'b010,
    ST_FINISH = 3'b100
  } load_state_t;

  typedef enum logic {
    MODE_FULL = 1'b0,
    MODE_MAC  = 1'b1
  } load_mode_t;

endpackage

// ===== verif/ee_model.sv
// behavioural serial memory answering the loader's byte fetches
`timescale 1ns/10ps
`default_nettype none

module ee_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // pacing: high adds wait cycles between bytes
  input  wire logic       slow,
  // byte fetch
  input  wire logic       ee_req,
  input  wire logic [8:0] ee_addr,
  output var  logic       ee_valid,
  output var  logic [7:0] ee_data
);
  logic [7:0] img [512];
  logic [1:0] wait_q;

  // data toggles outside the strobe so no stale byte is seen
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ee_valid <= 1'b0;
      ee_data  <= 8'h3c;
      wait_q   <= 2'h0;
    end else if (ee_valid) begin
      ee_valid <= 1'b0;
      ee_data  <= ~ee_data;
      wait_q   <= slow ? 2'h3 : 2'h0;
    end else if (ee_req && wait_q == 2'h0) begin
      ee_valid <= 1'b1;
      ee_data  <= img[ee_addr];
    end else begin
      ee_data  <= ~ee_data;
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== verif/eeprom_config_image_loader_tb.sv
// self-checking bench for the configuration image loader
`timescale 1ns/10ps
`default_nettype none
`include "loader_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module eeprom_config_image_loader_tb;
  import loader_pkg::*;
  logic        mclk, rst_b, sys_reload, usb_reset, ee_req, ee_valid, reg_wr, reg_rd;
  logic        phy_disconnect, load_done, slow, prog_exp;
  logic [8:0]  ee_addr, desc_addr;
  logic [7:0]  ee_data, desc_data, reg_addr;
  logic [47:0] mac_addr;
  logic [11:0] wk_en, wk_pol;
  logic [31:0] reg_wdata, reg_rdata, d, seed;
  int          err_total, checked;

  eeprom_config_image_loader uut (
    .mclk, .rst_b, .sys_reload, .usb_reset, .ee_req, .ee_addr, .ee_valid, .ee_data,
    .desc_addr, .desc_data, .mac_addr, .gpio_wake_enable_field(wk_en),
    .gpio_wake_polarity_field(wk_pol), .phy_disconnect, .load_done,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );
  ee_model u_ee (.mclk, .rst_b, .slow, .ee_req, .ee_addr, .ee_valid, .ee_data);

  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // absent image reads as the defaults
  function automatic logic [7:0] b(int a);
    return prog_exp ? u_ee.img[a] : ((a >= 16 && a <= 18) ? `DEF_IV : `DEF_BYTE);
  endfunction
  function automatic logic [31:0] w32(int a);
    return {b(a + 3), b(a + 2), b(a + 1), b(a)};
  endfunction
  function automatic logic [31:0] ptr(int a);
    return {b(a) != 8'h00, 6'h00, b(a + 1), 1'b0, 8'h00, b(a)};
  endfunction

  // ==========================================================
  // bus tasks
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic pulse(input logic usb);
    @(posedge mclk);
    if (usb) usb_reset <= 1'b1;
    else sys_reload <= 1'b1;
    @(posedge mclk);
    usb_reset  <= 1'b0;
    sys_reload <= 1'b0;
  endtask
  task automatic conclude();
    $display("counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    repeat (4) @(posedge mclk);
    for (n = 0; n < 3000; n++) begin
      rd(`REG_STATUS);
      if (d[2] === 1'b0) break;
    end
    if (n == 3000) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic fill(input logic strings);
    int i;
    logic [31:0] e;
    for (i = 0; i < 512; i++) begin
      e = rnd();
      u_ee.img[i] = e[7:0];
    end
    u_ee.img[0] = `IMG_MARK;
    for (i = 11; i < 14; i++) u_ee.img[i] = 8'h00;
    for (i = 0; i < 6; i++) u_ee.img[49 + 2 * i] = (i == 1) ? 8'h00 : `IMG_FIX_LEN;
    for (i = 0; i < 5; i++) begin
      if (!strings || i == 2) begin
        u_ee.img[37 + 2 * i] = 8'h00;
        u_ee.img[38 + 2 * i] = 8'h00;
      end
    end
  endtask

  // ==========================================================
  // full comparison of all loaded fields against the image
  task automatic check_load();
    int i;
    logic any, lerr;
    logic [31:0] e, f;
    e = w32(1);
    f = w32(5);
    `CHK(mac_addr, {f[15:0], e})
    e = w32(7);
    f = w32(14);
    `CHK(wk_en, e[11:0])
    `CHK(wk_pol, f[11:0])
    rd(`REG_WAKE);
    `CHK(d, {4'h0, f[11:0], 4'h0, e[11:0]})
    rd(`REG_IVAL);
    e = w32(16);
    `CHK(d, {8'h00, e[23:0]})
    for (i = 0; i < 4; i++) begin
      rd(`REG_FLAGS0 + 8'(4 * i));
      `CHK(d, w32(19 + 4 * i))
    end
    any = 1'b0;
    lerr = 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(`REG_STR0 + 8'(4 * i));
      `CHK(d, ptr(37 + 2 * i))
      any |= b(37 + 2 * i) != 8'h00;
    end
    for (i = 0; i < 6; i++) lerr |= b(49 + 2 * i) != 8'h00 && b(49 + 2 * i) != `IMG_FIX_LEN;
    rd(`REG_LANG);
    e = w32(35);
    `CHK(d, any ? {16'h0000, e[15:0]} : 32'h0)
    rd(`REG_BOS);
    `CHK(d, ptr(47) & 32'h7fffffff)
    rd(`REG_STATUS);
    `CHK(d, {27'h0, lerr, any, 1'b0, prog_exp, 1'b1})
    `CHK(phy_disconnect, 1'b0)
    for (i = 0; i < 8 && prog_exp; i++) begin
      e = rnd();
      @(posedge mclk);
      desc_addr <= (i == 0) ? `IMG_LAST : e[8:0];
      @(posedge mclk);
      #1 `CHK(desc_data, u_ee.img[desc_addr])
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    logic [7:0] x;
    logic [31:0] e, f, g;
    int i;
    rst_b = 1'b0; sys_reload = 1'b0; usb_reset = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; desc_addr = 9'h000; slow = 1'b0;
    seed = 32'd17; prog_exp = 1'b0; err_total = 0; checked = 0;
    fill(1'b1);
    u_ee.img[0] = 8'h5a;
    repeat (6) @(posedge mclk);
    #1 `CHK(phy_disconnect, 1'b1)
    `CHK(load_done, 1'b0)
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK(phy_disconnect, 1'b1)
    wait_idle();
    check_load();
    `CHK(load_done, 1'b1)
    `CHK(ee_addr, `IMG_MARK_ADDR)
    `CHK(ee_req, 1'b0)
    $display("test unprogrammed image done");
    fill(1'b1);
    prog_exp = 1'b1;
    slow = 1'b1;
    wr(`REG_CTRL, 32'h1);
    wait_idle();
    check_load();
    `CHK(ee_addr, `IMG_LAST)
    rd(8'h80);
    `CHK(d, 32'h0)
    @(posedge mclk);
    #1 `CHK(reg_rdata, 32'h0)
    $display("test programmed image done");
    x = u_ee.img[1];
    e = w32(7);
    for (i = 1; i < 9; i++) begin
      f = rnd();
      u_ee.img[i] = f[7:0];
    end
    pulse(1'b1);
    wait_idle();
    f = w32(1);
    g = w32(5);
    `CHK(mac_addr, {g[15:0], f})
    `CHK(wk_en, e[11:0])
    `CHK(ee_addr, `IMG_MAC5)
    @(posedge mclk);
    desc_addr <= 9'h001;
    @(posedge mclk);
    #1 `CHK(desc_data, x)
    $display("test address-only reload done");
    fill(1'b0);
    u_ee.img[51] = 8'h07;
    slow = 1'b0;
    pulse(1'b0);
    wait_idle();
    check_load();
    $display("test no strings done");
    conclude();
  end
endmodule

`default_nettype wire
